// >>> shared/ichp_pkg.sv
`default_nettype none
package ichp_pkg;
  localparam int  NUM_GROUPS      = 4;
  localparam int  TRANSFER_GROUP  = 3;
  localparam int  DATA_WIDTH      = 48;
  localparam int  CODE_WIDTH      = 12;
  localparam int  COUNT_WIDTH     = 16;
  localparam int  FIFO_DEPTH      = 8;
  localparam int  CLOCK_MHZ       = 200;
  localparam real STROBE_US       = 4.8;
  localparam int  STROBE_CYCLES   = int'(STROBE_US * CLOCK_MHZ);
  localparam int  STROBE_W        = $clog2(STROBE_CYCLES + 1);
  localparam int  SETTLE_CYCLES   = 2;
  localparam int  SETTLE_W        = 2;

  // One bit per strobe line, in the order used on the link.
  typedef enum logic [3:0] {
    ICHP_FUNC_IN   = 4'h1,
    ICHP_FUNC_OUT  = 4'h2,
    ICHP_SENSE_IN  = 4'h4,
    ICHP_SENSE_OUT = 4'h8
  } ichp_cmd_type;
endpackage : ichp_pkg
`default_nettype wire

// >>> shared/ichp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ichp_link_if;
  logic [ichp_pkg::DATA_WIDTH-1:0] inData;
  logic                            inReady;
  logic                            inResume;
  logic [ichp_pkg::DATA_WIDTH-1:0] outData;
  logic                            outReady;
  logic                            outResume;
  logic                            inActive;
  logic                            outActive;
  logic                            masterClear;
  logic                            interrupt;
  logic [3:0]                      strobe;
  logic [ichp_pkg::CODE_WIDTH-1:0] funcCode;
  logic                            senseReply;

  modport computer (
    input  inData, inReady, outResume, interrupt, senseReply,
    output inResume, outData, outReady, inActive, outActive, masterClear, strobe, funcCode
  );
  modport device (
    output inData, inReady, outResume, interrupt, senseReply,
    input  inResume, outData, outReady, inActive, outActive, masterClear, strobe, funcCode
  );
endinterface : ichp_link_if
`default_nettype wire

// >>> hw/ichp_computer_end.sv
// Contract
// - Four cable groups, one input one output each.
// - Peripheral uses channels of one group only.
// - Separate 48-line input and output data paths.
// - Peripheral holds input ready until resume seen.
// - Raise resume on accept, drop after ready falls.
// - Output ready with each word, drop on resume.
// - Peripheral resumes after taking, drops after ready.
// - Input active until last word resumed.
// - Output active until last word delivered.
// - Clear line follows operator clear; peripherals reset.
// - Peripheral holds interrupt until condition removed.
// - Function strobes pulse with code, 4.8 us.
// - Sense strobes pulse with code, 4.8 us.
// - Peripheral holds sense reply across strobe window.
// - Peripheral reads function code only during strobes.
// - Transfer group leaves four control lines unused.
// - Transfer group never overlaps input and output.
// - Input block: select, activate, repeat word exchanges.
// - Peripheral drops ready, presents next word parallel.
// - Output ready only after data lines settle.
// - Peripheral accepts at own pace, then resumes.
// - Repeat output exchange, then drop output active.
`timescale 1ns/1ps
`default_nettype none
module ichp_fifo #(
  parameter int WIDTH = ichp_pkg::DATA_WIDTH,
  parameter int DEPTH = ichp_pkg::FIFO_DEPTH
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic             wrValid,
  output logic                  wrReady,
  input  wire logic [WIDTH-1:0] wrData,
  output logic                  rdValid,
  input  wire logic             rdReady,
  output logic [WIDTH-1:0]      rdData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      fill;
  wire              push = wrValid && wrReady;
  wire              pop  = rdValid && rdReady;

  assign wrReady = fill != (AW+1)'(DEPTH);
  assign rdValid = fill != '0;
  assign rdData  = mem[rdPtr];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wrPtr] <= wrData;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
      fill  <= '0;
    end else begin
      if (push) wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      if (pop) rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : ichp_fifo

module ichp_computer_end #(
  parameter int GROUP_INDEX = 0,
  parameter int FIFO_WIDTH  = ichp_pkg::DATA_WIDTH,
  parameter int FIFO_DEPTH  = ichp_pkg::FIFO_DEPTH
) (
  input  wire logic                              clock,
  input  wire logic                              arst_n,
  input  wire logic                              opClear,
  input  wire logic                              cmdValid,
  output logic                                   cmdReady,
  input  wire ichp_pkg::ichp_cmd_type            cmdKind,
  input  wire logic [ichp_pkg::CODE_WIDTH-1:0]   cmdCode,
  output logic                                   senseDone,
  output logic                                   senseResult,
  input  wire logic                              inStart,
  input  wire logic [ichp_pkg::COUNT_WIDTH-1:0]  inCount,
  output logic                                   inBusy,
  output logic                                   inWordValid,
  input  wire logic                              inWordReady,
  output logic [ichp_pkg::DATA_WIDTH-1:0]        inWordData,
  input  wire logic                              outStart,
  input  wire logic [ichp_pkg::COUNT_WIDTH-1:0]  outCount,
  output logic                                   outBusy,
  input  wire logic                              outWordValid,
  output logic                                   outWordReady,
  input  wire logic [FIFO_WIDTH-1:0]             outWordData,
  output logic                                   interruptLevel,
  ichp_link_if.computer                          link
);
  typedef enum logic [2:0] {I_IDLE = 3'h1, I_WAIT = 3'h2, I_ACK = 3'h4} ichp_in_type;
  typedef enum logic [3:0] {O_IDLE = 4'h1, O_LOAD = 4'h2, O_READY = 4'h4, O_DROP = 4'h8} ichp_out_type;
  typedef enum logic [1:0] {F_IDLE = 2'h1, F_STROBE = 2'h2} ichp_fn_type;

  localparam bit IS_TRANSFER = (GROUP_INDEX == ichp_pkg::TRANSFER_GROUP);

  if (GROUP_INDEX < 0 || GROUP_INDEX >= ichp_pkg::NUM_GROUPS) begin : gBadGroup
    $error("Group index out of range.");
  end

  // The peripheral runs on its own timing, so its levels pass two flops first.
  logic [3:0] meta;
  logic [3:0] seen;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta <= '0;
      seen <= '0;
    end else begin
      meta <= {link.interrupt, link.senseReply, link.outResume, link.inReady};
      seen <= meta;
    end
  end
  wire inReadySeen   = seen[0];
  wire outResumeSeen = seen[1];
  wire senseSeen     = seen[2];
  assign interruptLevel = seen[3];

  ichp_in_type                    inState;
  ichp_in_type                    next_inState;
  logic [ichp_pkg::COUNT_WIDTH-1:0] inLeft;
  logic [ichp_pkg::COUNT_WIDTH-1:0] next_inLeft;
  ichp_out_type                   outState;
  ichp_out_type                   next_outState;
  logic [ichp_pkg::COUNT_WIDTH-1:0] outLeft;
  logic [ichp_pkg::COUNT_WIDTH-1:0] next_outLeft;
  logic [ichp_pkg::SETTLE_W-1:0]  settle;
  logic [ichp_pkg::DATA_WIDTH-1:0] outDataReg;
  ichp_fn_type                    fnState;
  ichp_pkg::ichp_cmd_type         fnKind;
  logic [ichp_pkg::CODE_WIDTH-1:0] fnCode;
  logic [ichp_pkg::STROBE_W-1:0]  strobeCnt;
  logic                           fifoValid;
  logic [FIFO_WIDTH-1:0]          fifoData;

  assign inBusy  = inState != I_IDLE;
  assign outBusy = outState != O_IDLE;

  // A transfer group has one control set, so a block may start only when the other direction is quiet.
  wire inGo    = inStart && !inBusy && inCount != '0 && !opClear && !(IS_TRANSFER && outBusy);
  wire outGo   = outStart && !outBusy && outCount != '0 && !opClear && !(IS_TRANSFER && (inBusy || inStart));
  wire inTake  = inState == I_WAIT && inReadySeen && inWordReady;
  wire fifoPop = outState == O_LOAD && fifoValid && settle == '0;
  wire settled = settle == ichp_pkg::SETTLE_W'(ichp_pkg::SETTLE_CYCLES);
  wire fnTake  = cmdValid && cmdReady;
  wire fnLast  = fnState == F_STROBE && strobeCnt == ichp_pkg::STROBE_W'(ichp_pkg::STROBE_CYCLES - 1);

  always_comb begin
    next_inState = inState;
    next_inLeft  = inLeft;
    unique case (inState)
      I_IDLE: begin
        if (inGo) begin
          next_inState = I_WAIT;
          next_inLeft  = inCount;
        end
      end
      I_WAIT: begin
        if (inTake) next_inState = I_ACK;
      end
      I_ACK: begin
        if (!inReadySeen) begin
          next_inLeft  = inLeft - 1'b1;
          next_inState = (inLeft == ichp_pkg::COUNT_WIDTH'(1)) ? I_IDLE : I_WAIT;
        end
      end
    endcase
    if (opClear) next_inState = I_IDLE;
  end

  always_comb begin
    next_outState = outState;
    next_outLeft  = outLeft;
    unique case (outState)
      O_IDLE: begin
        if (outGo) begin
          next_outState = O_LOAD;
          next_outLeft  = outCount;
        end
      end
      O_LOAD: begin
        if (settled) next_outState = O_READY;
      end
      O_READY: begin
        if (outResumeSeen) next_outState = O_DROP;
      end
      O_DROP: begin
        if (!outResumeSeen) begin
          next_outLeft  = outLeft - 1'b1;
          next_outState = (outLeft == ichp_pkg::COUNT_WIDTH'(1)) ? O_IDLE : O_LOAD;
        end
      end
    endcase
    if (opClear) next_outState = O_IDLE;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      inState  <= I_IDLE;
      inLeft   <= '0;
      outState <= O_IDLE;
      outLeft  <= '0;
    end else begin
      inState  <= next_inState;
      inLeft   <= next_inLeft;
      outState <= next_outState;
      outLeft  <= next_outLeft;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      inWordValid <= 1'b0;
      inWordData  <= '0;
    end else begin
      inWordValid <= inTake;
      if (inTake) inWordData <= link.inData;
    end
  end

  // The word is held on the lines a few cycles before ready rises.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      outDataReg <= '0;
      settle     <= '0;
    end else begin
      if (fifoPop) outDataReg <= ichp_pkg::DATA_WIDTH'(fifoData);
      if (outState != O_LOAD) settle <= '0;
      else if (fifoPop || (settle != '0 && !settled)) settle <= settle + 1'b1;
    end
  end

  ichp_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) outFifo (
    .clock   (clock),
    .arst_n  (arst_n),
    .wrValid (outWordValid),
    .wrReady (outWordReady),
    .wrData  (outWordData),
    .rdValid (fifoValid),
    .rdReady (fifoPop),
    .rdData  (fifoData)
  );

  assign cmdReady = fnState == F_IDLE;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      fnState     <= F_IDLE;
      fnKind      <= ichp_pkg::ICHP_FUNC_IN;
      fnCode      <= '0;
      strobeCnt   <= '0;
      senseDone   <= 1'b0;
      senseResult <= 1'b0;
    end else begin
      senseDone <= 1'b0;
      if (fnTake) begin
        fnState   <= F_STROBE;
        fnKind    <= cmdKind;
        fnCode    <= cmdCode;
        strobeCnt <= '0;
      end else if (fnLast) begin
        fnState     <= F_IDLE;
        senseDone   <= fnKind == ichp_pkg::ICHP_SENSE_IN || fnKind == ichp_pkg::ICHP_SENSE_OUT;
        senseResult <= senseSeen;
      end else if (fnState == F_STROBE) begin
        strobeCnt <= strobeCnt + 1'b1;
      end
    end
  end

  // Input-side control lines stay low on the transfer group.
  wire [3:0] unusedMask = IS_TRANSFER ? 4'hA : 4'hF;
  wire [3:0] strobeRaw  = (fnState == F_STROBE) ? fnKind : 4'h0;

  assign link.strobe      = strobeRaw & unusedMask;
  assign link.funcCode    = fnCode;
  assign link.inResume    = inState == I_ACK;
  assign link.inActive    = inBusy && !IS_TRANSFER;
  assign link.outActive   = outBusy && !IS_TRANSFER;
  assign link.outReady    = outState == O_READY;
  assign link.outData     = outDataReg;
  assign link.masterClear = opClear;
endmodule : ichp_computer_end
`default_nettype wire

// >>> hw/ichp_device_end.sv
`timescale 1ns/1ps
`default_nettype none
module ichp_device_end (
  input  wire logic                             clock,
  input  wire logic                             arst_n,
  output logic                                  devClear,
  input  wire logic                             srcValid,
  output logic                                  srcReady,
  input  wire logic [ichp_pkg::DATA_WIDTH-1:0]  srcData,
  output logic                                  sinkValid,
  input  wire logic                             sinkReady,
  output logic [ichp_pkg::DATA_WIDTH-1:0]       sinkData,
  output logic                                  funcValid,
  output ichp_pkg::ichp_cmd_type                funcKind,
  output logic [ichp_pkg::CODE_WIDTH-1:0]       funcCode,
  input  wire logic                             senseCondition,
  input  wire logic                             irqRequest,
  output logic                                  inBlockSeen,
  output logic                                  outBlockSeen,
  ichp_link_if.device                           link
);
  typedef enum logic [2:0] {P_IDLE = 3'h1, P_READY = 3'h2, P_DROP = 3'h4} ichp_src_type;
  typedef enum logic [1:0] {Q_IDLE = 2'h1, Q_ACK = 2'h2} ichp_sink_type;

  logic [8:0] meta;
  logic [8:0] seen;
  logic [3:0] strobePrev;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta       <= '0;
      seen       <= '0;
      strobePrev <= '0;
    end else begin
      meta       <= {link.strobe, link.masterClear, link.outActive, link.inActive, link.outReady, link.inResume};
      seen       <= meta;
      strobePrev <= seen[8:5];
    end
  end
  wire       resumeSeen   = seen[0];
  wire       outReadySeen = seen[1];
  wire       clearSeen    = seen[4];
  wire [3:0] strobeSeen   = seen[8:5];
  wire [3:0] strobeRise   = strobeSeen & ~strobePrev;
  wire       senseWindow  = strobeSeen[2] || strobeSeen[3];

  assign devClear     = clearSeen;
  assign inBlockSeen  = seen[2];
  assign outBlockSeen = seen[3];

  ichp_src_type                    srcState;
  ichp_sink_type                   sinkState;
  logic [ichp_pkg::DATA_WIDTH-1:0] inDataReg;

  assign srcReady = srcState == P_IDLE && !clearSeen;
  wire srcTake  = srcValid && srcReady;
  wire sinkTake = sinkState == Q_IDLE && outReadySeen && sinkReady && !clearSeen;

  // The word is loaded on the same edge that ready rises, and the computer's two-flop delay keeps it stable when sampled.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      srcState  <= P_IDLE;
      inDataReg <= '0;
    end else if (clearSeen) begin
      srcState <= P_IDLE;
    end else begin
      unique case (srcState)
        P_IDLE: begin
          if (srcTake) begin
            inDataReg <= srcData;
            srcState  <= P_READY;
          end
        end
        P_READY: begin
          if (resumeSeen) srcState <= P_DROP;
        end
        P_DROP: begin
          if (!resumeSeen) srcState <= P_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sinkState <= Q_IDLE;
      sinkValid <= 1'b0;
      sinkData  <= '0;
    end else begin
      sinkValid <= sinkTake;
      if (sinkTake) sinkData <= link.outData;
      if (clearSeen) sinkState <= Q_IDLE;
      else if (sinkTake) sinkState <= Q_ACK;
      else if (sinkState == Q_ACK && !outReadySeen) sinkState <= Q_IDLE;
    end
  end

  // The code lines are only trusted on the strobe's rising edge.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      funcValid <= 1'b0;
      funcKind  <= ichp_pkg::ICHP_FUNC_IN;
      funcCode  <= '0;
    end else begin
      funcValid <= strobeRise != 4'h0 && !clearSeen;
      if (strobeRise != 4'h0) begin
        funcKind <= ichp_pkg::ichp_cmd_type'(strobeRise);
        funcCode <= link.funcCode;
      end
    end
  end

  logic replyReg;
  logic irqReg;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      replyReg <= 1'b0;
      irqReg   <= 1'b0;
    end else begin
      replyReg <= senseWindow && senseCondition && !clearSeen;
      irqReg   <= irqRequest && !clearSeen;
    end
  end

  assign link.inData     = inDataReg;
  assign link.inReady    = srcState == P_READY;
  assign link.outResume  = sinkState == Q_ACK;
  assign link.senseReply = replyReg;
  assign link.interrupt  = irqReg;
endmodule : ichp_device_end
`default_nettype wire

// >>> verification/ichp_link_props.sv
`timescale 1ns/1ps
`default_nettype none
module ichp_link_props (
  input wire logic                            clock,
  input wire logic                            arst_n,
  input wire logic                            inReady,
  input wire logic                            inResume,
  input wire logic [ichp_pkg::DATA_WIDTH-1:0] outData,
  input wire logic                            outReady,
  input wire logic                            outResume,
  input wire logic                            inActive,
  input wire logic                            outActive,
  input wire logic                            masterClear,
  input wire logic [3:0]                      strobe,
  input wire logic [ichp_pkg::CODE_WIDTH-1:0] funcCode,
  input wire logic                            senseReply
);
  localparam int STROBE = ichp_pkg::STROBE_CYCLES;
  logic [ichp_pkg::STROBE_W-1:0] strobeLen;

  // A counter stands in for a 960-long repetition, which the tools could not unroll.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      strobeLen <= '0;
    end else if (strobe != 4'h0) begin
      strobeLen <= strobeLen + 1'b1;
    end else begin
      strobeLen <= '0;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n || masterClear);

  sequence strobeHeldS;
    strobe != 4'h0 ##1 strobe != 4'h0;
  endsequence
  sequence strobeEndS;
    strobeLen != '0 && strobe == 4'h0;
  endsequence
  sequence wordHeldS;
    outReady ##1 outReady;
  endsequence

  strobe_onehot_a: assert property ($onehot0(strobe)) else $error("Two strobes at once.");
  strobe_width_a: assert property (strobe != 4'h0 |-> strobeLen < STROBE) else $error("Strobe too long.");
  strobe_end_a: assert property (strobeEndS |-> strobeLen == STROBE) else $error("Strobe too short.");
  code_hold_a: assert property (strobeHeldS |-> $stable(strobe) && $stable(funcCode))
    else $error("Code or strobe moved in a strobe.");
  in_ack_a: assert property ($rose(inResume) |-> inReady) else $error("Resume without ready.");
  in_release_a: assert property ($fell(inReady) |-> ##[1:4] !inResume) else $error("Resume stuck.");
  in_offer_a: assert property ($rose(inReady) |-> !inResume) else $error("Ready under resume.");
  in_done_a: assert property ($fell(inActive) |-> !inResume) else $error("Input active dropped early.");
  out_drop_a: assert property ($rose(outResume) |-> ##[1:4] !outReady) else $error("Output ready stuck.");
  out_ack_a: assert property ($rose(outResume) |-> outReady) else $error("Resume without ready.");
  out_settle_a: assert property (wordHeldS |-> $stable(outData)) else $error("Output data moved.");
  out_fresh_a: assert property ($rose(outReady) |-> !outResume) else $error("Ready under resume.");
  out_done_a: assert property ($fell(outActive) |-> !outReady && !outResume)
    else $error("Output active dropped early.");
  sense_end_a: assert property (($fell(strobe[2]) || $fell(strobe[3])) |-> ##[0:4] !senseReply)
    else $error("Sense reply outlived strobe.");
endmodule : ichp_link_props
`default_nettype wire

// >>> verification/io_channel_handshake_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin testsRun++; if ((g) !== (e)) begin nFail++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module io_channel_handshake_port_tb_top;
  logic                             clock, arst_n, opClear, cmdValid, cmdReady, senseDone, senseResult;
  logic                             inStart, inBusy, inWordValid, inWordReady, outStart, outBusy;
  logic                             outWordValid, outWordReady, interruptLevel, devClear, srcValid, srcReady;
  logic                             sinkValid, sinkReady, funcValid, senseCondition, irqRequest, gotSense;
  logic                             inSeen, outSeen;
  logic [ichp_pkg::DATA_WIDTH-1:0]  inWordData, outWordData, srcData, sinkData;
  logic [ichp_pkg::DATA_WIDTH-1:0]  inGot[$], sinkGot[$];
  logic [ichp_pkg::CODE_WIDTH-1:0]  cmdCode, devFuncCode, gotCode;
  logic [ichp_pkg::COUNT_WIDTH-1:0] inCount, outCount;
  ichp_pkg::ichp_cmd_type           cmdKind, funcKind, gotKind;
  ichp_pkg::ichp_cmd_type           kinds[6];
  int                               nFail, testsRun, cycles;

  ichp_link_if link ();
  ichp_computer_end ichp_computer_end_i (.clock(clock), .arst_n(arst_n), .opClear(opClear), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdKind(cmdKind), .cmdCode(cmdCode), .senseDone(senseDone), .senseResult(senseResult),
    .inStart(inStart), .inCount(inCount), .inBusy(inBusy), .inWordValid(inWordValid), .inWordReady(inWordReady),
    .inWordData(inWordData), .outStart(outStart), .outCount(outCount), .outBusy(outBusy),
    .outWordValid(outWordValid), .outWordReady(outWordReady), .outWordData(outWordData),
    .interruptLevel(interruptLevel), .link(link.computer));
  ichp_device_end ichp_device_end_i (.clock(clock), .arst_n(arst_n), .devClear(devClear), .srcValid(srcValid),
    .srcReady(srcReady), .srcData(srcData), .sinkValid(sinkValid), .sinkReady(sinkReady), .sinkData(sinkData),
    .funcValid(funcValid), .funcKind(funcKind), .funcCode(devFuncCode), .senseCondition(senseCondition),
    .irqRequest(irqRequest), .inBlockSeen(inSeen), .outBlockSeen(outSeen), .link(link.device));
  ichp_link_props ichp_link_props_i (.clock(clock), .arst_n(arst_n), .inReady(link.inReady),
    .inResume(link.inResume), .outData(link.outData), .outReady(link.outReady), .outResume(link.outResume),
    .inActive(link.inActive), .outActive(link.outActive), .masterClear(link.masterClear),
    .strobe(link.strobe), .funcCode(link.funcCode), .senseReply(link.senseReply));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Pulses from both ends are caught here so no one-cycle output is missed by a busy task.
  always @(posedge clock) begin
    cycles++;
    if (inWordValid === 1'b1) inGot.push_back(inWordData);
    if (sinkValid === 1'b1) sinkGot.push_back(sinkData);
    if (funcValid === 1'b1) begin
      gotKind = funcKind;
      gotCode = devFuncCode;
    end
    if (senseDone === 1'b1) gotSense = senseResult;
    if (cycles == 20000) begin
      nFail++;
      summarize();
    end
  end

  function automatic logic [ichp_pkg::DATA_WIDTH-1:0] pat(input int i);
    return 48'hF0E1_D2C3_B4A5 ^ (48'h0101_0101_0101 * 48'(i));
  endfunction : pat

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask : tick

  task automatic doCmd(input ichp_pkg::ichp_cmd_type k, input logic [11:0] c, input logic cond);
    int         len;
    logic [3:0] seen;
    len = 0;
    seen = 4'h0;
    senseCondition = cond;
    cmdKind = k;
    cmdCode = c;
    cmdValid = 1'b1;
    do @(posedge clock); while (cmdReady !== 1'b1);
    #1 cmdValid = 1'b0;
    do begin
      @(posedge clock);
      seen = seen | link.strobe;
      if (link.strobe !== 4'h0) len++;
    end while (len == 0 || link.strobe !== 4'h0);
    tick(4);
    `CHK(len, ichp_pkg::STROBE_CYCLES)
    `CHK(seen, 4'(k))
    `CHK(gotKind, k)
    `CHK(gotCode, c)
    if (k[2] || k[3]) `CHK(gotSense, cond)
  endtask : doCmd

  task automatic sendSrc(input logic [ichp_pkg::DATA_WIDTH-1:0] d);
    srcData = d;
    srcValid = 1'b1;
    do @(posedge clock); while (srcReady !== 1'b1);
    #1;
  endtask : sendSrc

  task automatic pushOut(input logic [ichp_pkg::DATA_WIDTH-1:0] d);
    outWordData = d;
    outWordValid = 1'b1;
    do @(posedge clock); while (outWordReady !== 1'b1);
    #1;
  endtask : pushOut

  task automatic runIn(input int n);
    inCount = 16'(n);
    inStart = 1'b1;
    tick(1);
    inStart = 1'b0;
    sendSrc(pat(0));
    tick(30);
    `CHK(link.inResume, 1'b0)
    `CHK(link.inActive, 1'b1)
    `CHK(inSeen, 1'b1)
    inWordReady = 1'b1;
    for (int k = 1; k < n; k++) sendSrc(pat(k));
    srcValid = 1'b0;
    while (inBusy !== 1'b0) tick(1);
    `CHK(link.inActive, 1'b0)
    `CHK(inGot.size(), n)
    for (int k = 0; k < n; k++) `CHK(inGot[k], pat(k))
  endtask : runIn

  task automatic runOut();
    for (int k = 0; k < 8; k++) pushOut(pat(k + 20));
    outWordValid = 1'b0;
    tick(2);
    `CHK(outWordReady, 1'b0)
    outCount = 16'h000A;
    outStart = 1'b1;
    tick(1);
    outStart = 1'b0;
    tick(30);
    `CHK(link.outReady, 1'b1)
    `CHK(link.outResume, 1'b0)
    `CHK(link.outActive, 1'b1)
    `CHK(outSeen, 1'b1)
    sinkReady = 1'b1;
    for (int k = 8; k < 10; k++) pushOut(pat(k + 20));
    outWordValid = 1'b0;
    while (outBusy !== 1'b0) tick(1);
    `CHK(link.outActive, 1'b0)
    `CHK(sinkGot.size(), 10)
    for (int k = 0; k < 10; k++) `CHK(sinkGot[k], pat(k + 20))
  endtask : runOut

  task automatic summarize();
    $display("checks %0d mismatches %0d", testsRun, nFail);
    if (nFail == 0 && testsRun > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    kinds = '{ichp_pkg::ICHP_FUNC_IN, ichp_pkg::ICHP_FUNC_OUT, ichp_pkg::ICHP_SENSE_IN,
              ichp_pkg::ICHP_SENSE_OUT, ichp_pkg::ICHP_SENSE_IN, ichp_pkg::ICHP_SENSE_OUT};
    arst_n = 1'b0;
    {opClear, cmdValid, inStart, inWordReady, outStart, outWordValid} = '0;
    {srcValid, sinkReady, senseCondition, irqRequest} = '0;
    cmdKind = ichp_pkg::ICHP_FUNC_IN;
    {cmdCode, inCount, outCount, outWordData, srcData} = '0;
    tick(10);
    arst_n = 1'b1;
    tick(2);
    for (int i = 0; i < 6; i++) doCmd(kinds[i], 12'hA50 + 12'(i), i < 4);
    $display("test function and sense done");
    runIn(3);
    $display("test input block done");
    runOut();
    $display("test output block done");
    irqRequest = 1'b1;
    tick(8);
    `CHK(interruptLevel, 1'b1)
    `CHK({inSeen, outSeen}, 2'b00)
    irqRequest = 1'b0;
    tick(8);
    `CHK(interruptLevel, 1'b0)
    opClear = 1'b1;
    tick(5);
    `CHK(link.masterClear, 1'b1)
    `CHK(devClear, 1'b1)
    `CHK(srcReady, 1'b0)
    opClear = 1'b0;
    tick(5);
    `CHK(devClear, 1'b0)
    $display("test interrupt and clear done");
    summarize();
  end
endmodule : io_channel_handshake_port_tb_top
`default_nettype wire
